// ==== core/aprc_consts.vh ====
// Register offsets, field positions and reset values of the power, interrupt and format registers.
// Assumes the includer places the register bank on a byte-wide serial register port.
`ifndef APRC_CONSTS_VH
`define APRC_CONSTS_VH

// Register offsets
`define APRC_OFS_RATE 6'h2c
`define APRC_OFS_POWER 6'h2d
`define APRC_OFS_IRQEN 6'h2e
`define APRC_OFS_ROUTE 6'h2f
`define APRC_OFS_FLAGS 6'h30
`define APRC_OFS_FORMAT 6'h31

// Rate control fields
`define APRC_RATE_LOWPWR 4
`define APRC_RATE_CODE_HI 3
`define APRC_RATE_RST 8'h0a
`define APRC_RATE_MASK 8'h1f

// Power mode control fields
`define APRC_PWR_CHAIN 5
`define APRC_PWR_DOZE 4
`define APRC_PWR_MEASURE 3
`define APRC_PWR_SLEEP 2
`define APRC_PWR_WAKE_HI 1
`define APRC_PWR_RST 8'h00
`define APRC_PWR_MASK 8'h3f

// Interrupt source bit positions
`define APRC_SRC_DRDY 7
`define APRC_SRC_TAP1 6
`define APRC_SRC_TAP2 5
`define APRC_SRC_ACT 4
`define APRC_SRC_INACT 3
`define APRC_SRC_FALL 2
`define APRC_SRC_WMARK 1
`define APRC_SRC_OVRUN 0
`define APRC_SRC_DATA_MASK 8'h83
`define APRC_IRQ_RST 8'h00

// Output format control fields
`define APRC_FMT_STIM 7
`define APRC_FMT_WIRE3 6
`define APRC_FMT_INVERT 5
`define APRC_FMT_SCALED 3
`define APRC_FMT_LEFT 2
`define APRC_FMT_SPAN_HI 1
`define APRC_FMT_RST 8'h00
`define APRC_FMT_MASK 8'hef

`endif

// ==== core/aprc_fmt.v ====
// Output sample formatter: span scaling, clipping and justification.
// Assumes raw samples arrive at 2 mg per LSB in 13-bit two's complement on clk_sys.
`timescale 1ns/1ps
`include "aprc_consts.vh"

module aprc_fmt #(
   parameter RAW_W = 13,
   parameter OUT_W = 16
)(
   clk_sys,
   rst_b,
   sampleValid,
   sampleRaw,
   spanSel,
   scaledRes,
   leftAlign,
   sampleOut,
   sampleOutValid
);
   input wire clk_sys;
   input wire rst_b;
   input wire sampleValid;
   input wire [RAW_W-1:0] sampleRaw;
   input wire [1:0] spanSel;
   input wire scaledRes;
   input wire leftAlign;
   output reg [OUT_W-1:0] sampleOut;
   output reg sampleOutValid;

   reg signed [OUT_W-1:0] rawExt;
   reg signed [OUT_W-1:0] scaled;
   reg signed [OUT_W-1:0] limHi;
   reg signed [OUT_W-1:0] limLo;
   reg signed [OUT_W-1:0] clipped;
   reg [4:0] width;
   reg [OUT_W-1:0] formatted;

   always @*
   begin
      rawExt = {{(OUT_W-RAW_W){sampleRaw[RAW_W-1]}}, sampleRaw};
      // Fixed 10-bit mode coarsens the scale with span; scaled mode keeps 2 mg
      if (scaledRes)
      begin
         scaled = rawExt;
         width = 5'd10 + {3'b000, spanSel};
      end
      else
      begin
         scaled = rawExt >>> spanSel;
         width = 5'd10;
      end
      limHi = $signed((16'h0001 << (width - 5'd1)) - 16'h0001);
      limLo = -limHi - 16'sh0001;
      // Widest span fits its width exactly, so clipping never acts there
      if (spanSel != 2'b11 && scaled > limHi)
         clipped = limHi;
      else if (spanSel != 2'b11 && scaled < limLo)
         clipped = limLo;
      else
         clipped = scaled;
      if (leftAlign)
         formatted = clipped << (5'd16 - width);
      else
         formatted = clipped;
   end

   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         sampleOut <= 16'h0000;
         sampleOutValid <= 1'b0;
      end
      else
      begin
         sampleOutValid <= sampleValid;
         if (sampleValid)
            sampleOut <= formatted;
      end
   end
endmodule

// ==== core/aprc_regs.v ====
// Power, interrupt and output format register bank of a three-axis accelerometer core.
// Assumes a serial front end on clk_sys presents byte register accesses, and detection
// engines on clk_sys deliver one-cycle event pulses.
`timescale 1ns/1ps
`include "aprc_consts.vh"

module aprc_regs (
   clk_sys,
   rst_b,
   regAddr,
   regWrEn,
   regRdEn,
   regWrData,
   regRdData_q,
   evtPulse,
   axisDataRead,
   sampleValid,
   sampleRaw,
   actFuncOn,
   inactFuncOn,
   irqLineA_q,
   irqLineB_q,
   lowPower_q,
   rateCode_q,
   measureOn_q,
   sleepActive_q,
   dozeRateHz_q,
   fifoWriteEn_q,
   actDetectEn_q,
   inactDetectEn_q,
   stimForce_q,
   spiThreeWire_q,
   spanSel_q,
   axisData,
   axisDataValid
);
   input wire clk_sys;
   input wire rst_b;
   input wire [5:0] regAddr;
   input wire regWrEn;
   input wire regRdEn;
   input wire [7:0] regWrData;
   output reg [7:0] regRdData_q;
   input wire [7:0] evtPulse;
   input wire axisDataRead;
   input wire sampleValid;
   input wire [12:0] sampleRaw;
   input wire actFuncOn;
   input wire inactFuncOn;
   output reg irqLineA_q;
   output reg irqLineB_q;
   output wire lowPower_q;
   output wire [3:0] rateCode_q;
   output wire measureOn_q;
   output reg sleepActive_q;
   output reg [3:0] dozeRateHz_q;
   output reg fifoWriteEn_q;
   output reg actDetectEn_q;
   output reg inactDetectEn_q;
   output wire stimForce_q;
   output wire spiThreeWire_q;
   output wire [1:0] spanSel_q;
   output wire [15:0] axisData;
   output wire axisDataValid;

   reg [7:0] rateCtl_q;
   reg [7:0] powerCtl_q;
   reg [7:0] irqEnable_q;
   reg [7:0] irqRoute_q;
   reg [7:0] irqFlags_q;
   reg [7:0] fmtCtl_q;
   reg [7:0] irqFlags_d;
   reg inactPhase_q;
   reg autoAsleep_q;
   reg autoAsleep_d;
   reg inactPhase_d;
   reg [7:0] evtGated;
   reg [7:0] clrMask;
   reg [7:0] readMux;
   reg lineA_d;
   reg lineB_d;

   wire chainOn;
   wire dozeOn;
   wire sleepOn;
   wire sleeping;
   wire wrRate;
   wire wrPower;
   wire wrEnable;
   wire wrRoute;
   wire wrFormat;
   wire rdFlags;
   wire [7:0] pendA;
   wire [7:0] pendB;

   // Address match used by both the write and read paths
   function hit;
      input [5:0] addr;
      input [5:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // Doze code to sleep reading rate in Hz
   function [3:0] doze_hz;
      input [1:0] code;
      begin
         case (code)
            2'b00: doze_hz = 4'h8;
            2'b01: doze_hz = 4'h4;
            2'b10: doze_hz = 4'h2;
            default: doze_hz = 4'h1;
         endcase
      end
   endfunction

   assign chainOn = powerCtl_q[`APRC_PWR_CHAIN];
   assign dozeOn = powerCtl_q[`APRC_PWR_DOZE];
   assign sleepOn = powerCtl_q[`APRC_PWR_SLEEP];
   assign sleeping = sleepOn | autoAsleep_q;

   assign wrRate = regWrEn && hit(regAddr, `APRC_OFS_RATE);
   assign wrPower = regWrEn && hit(regAddr, `APRC_OFS_POWER);
   assign wrEnable = regWrEn && hit(regAddr, `APRC_OFS_IRQEN);
   assign wrRoute = regWrEn && hit(regAddr, `APRC_OFS_ROUTE);
   assign wrFormat = regWrEn && hit(regAddr, `APRC_OFS_FORMAT);
   assign rdFlags = regRdEn && hit(regAddr, `APRC_OFS_FLAGS);

   assign lowPower_q = rateCtl_q[`APRC_RATE_LOWPWR];
   assign rateCode_q = rateCtl_q[`APRC_RATE_CODE_HI:0];
   assign measureOn_q = powerCtl_q[`APRC_PWR_MEASURE];
   assign stimForce_q = fmtCtl_q[`APRC_FMT_STIM];
   assign spiThreeWire_q = fmtCtl_q[`APRC_FMT_WIRE3];
   assign spanSel_q = fmtCtl_q[`APRC_FMT_SPAN_HI:0];

   // Control registers; reserved bits are forced to zero
   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         rateCtl_q <= `APRC_RATE_RST;
         powerCtl_q <= `APRC_PWR_RST;
         irqEnable_q <= `APRC_IRQ_RST;
         irqRoute_q <= `APRC_IRQ_RST;
         fmtCtl_q <= `APRC_FMT_RST;
      end
      else
      begin
         if (wrRate)
            rateCtl_q <= regWrData & `APRC_RATE_MASK;
         if (wrPower)
            powerCtl_q <= regWrData & `APRC_PWR_MASK;
         if (wrEnable)
            irqEnable_q <= regWrData;
         if (wrRoute)
            irqRoute_q <= regWrData;
         if (wrFormat)
            fmtCtl_q <= regWrData & `APRC_FMT_MASK;
      end
   end

   // Chained detection and automatic doze
   always @*
   begin
      inactPhase_d = inactPhase_q;
      autoAsleep_d = autoAsleep_q;
      if (!chainOn || !measureOn_q)
      begin
         // Leaving chain or measurement restarts the chain at the inactivity watch
         inactPhase_d = 1'b1;
         autoAsleep_d = 1'b0;
      end
      else if (actFuncOn && inactFuncOn)
      begin
         if (inactPhase_q && evtGated[`APRC_SRC_INACT])
         begin
            inactPhase_d = 1'b0;
            if (dozeOn)
               autoAsleep_d = 1'b1;
         end
         else if (!inactPhase_q && evtGated[`APRC_SRC_ACT])
         begin
            inactPhase_d = 1'b1;
            autoAsleep_d = 1'b0;
         end
      end
      if (!dozeOn)
         autoAsleep_d = 1'b0;
   end

   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         inactPhase_q <= 1'b1;
         autoAsleep_q <= 1'b0;
         sleepActive_q <= 1'b0;
         dozeRateHz_q <= 4'h8;
         fifoWriteEn_q <= 1'b0;
         actDetectEn_q <= 1'b0;
         inactDetectEn_q <= 1'b0;
      end
      else
      begin
         inactPhase_q <= inactPhase_d;
         autoAsleep_q <= autoAsleep_d;
         sleepActive_q <= sleepOn | autoAsleep_d;
         dozeRateHz_q <= doze_hz(powerCtl_q[`APRC_PWR_WAKE_HI:0]);
         // Standby stops everything; sleep keeps only the activity watch
         fifoWriteEn_q <= measureOn_q && !(sleepOn | autoAsleep_d);
         if (!measureOn_q)
         begin
            actDetectEn_q <= 1'b0;
            inactDetectEn_q <= 1'b0;
         end
         else if (sleepOn | autoAsleep_d)
         begin
            actDetectEn_q <= actFuncOn;
            inactDetectEn_q <= 1'b0;
         end
         else if (chainOn && actFuncOn && inactFuncOn)
         begin
            actDetectEn_q <= !inactPhase_d;
            inactDetectEn_q <= inactPhase_d;
         end
         else
         begin
            actDetectEn_q <= actFuncOn;
            inactDetectEn_q <= inactFuncOn;
         end
      end
   end

   // Source flags; a new event in the clearing cycle wins over the clear
   always @*
   begin
      evtGated = evtPulse;
      if (sleeping)
         evtGated[`APRC_SRC_DRDY] = 1'b0;
      if (!actDetectEn_q)
         evtGated[`APRC_SRC_ACT] = 1'b0;
      if (!inactDetectEn_q)
         evtGated[`APRC_SRC_INACT] = 1'b0;
      clrMask = 8'h00;
      if (axisDataRead)
         clrMask = clrMask | `APRC_SRC_DATA_MASK;
      if (rdFlags)
         clrMask = clrMask | ~`APRC_SRC_DATA_MASK;
      // Flags set regardless of enables; enables only gate the lines
      irqFlags_d = (irqFlags_q & ~clrMask) | evtGated;
   end

   always @(posedge clk_sys)
   begin
      if (!rst_b)
         irqFlags_q <= `APRC_IRQ_RST;
      else
         irqFlags_q <= irqFlags_d;
   end

   // Interrupt lines follow the flags one cycle later
   assign pendA = irqFlags_q & irqEnable_q & ~irqRoute_q;
   assign pendB = irqFlags_q & irqEnable_q & irqRoute_q;

   always @*
   begin
      lineA_d = (|pendA) ^ fmtCtl_q[`APRC_FMT_INVERT];
      lineB_d = (|pendB) ^ fmtCtl_q[`APRC_FMT_INVERT];
   end

   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         irqLineA_q <= 1'b0;
         irqLineB_q <= 1'b0;
      end
      else
      begin
         irqLineA_q <= lineA_d;
         irqLineB_q <= lineB_d;
      end
   end

   // Read path; unmapped addresses read zero
   always @*
   begin
      if (hit(regAddr, `APRC_OFS_RATE))
         readMux = rateCtl_q;
      else if (hit(regAddr, `APRC_OFS_POWER))
         readMux = powerCtl_q;
      else if (hit(regAddr, `APRC_OFS_IRQEN))
         readMux = irqEnable_q;
      else if (hit(regAddr, `APRC_OFS_ROUTE))
         readMux = irqRoute_q;
      else if (hit(regAddr, `APRC_OFS_FLAGS))
         readMux = irqFlags_q;
      else if (hit(regAddr, `APRC_OFS_FORMAT))
         readMux = fmtCtl_q;
      else
         readMux = 8'h00;
   end

   always @(posedge clk_sys)
   begin
      if (!rst_b)
         regRdData_q <= 8'h00;
      else if (regRdEn)
         regRdData_q <= readMux;
   end

   aprc_fmt #(
      .RAW_W(13),
      .OUT_W(16)
   ) uFmt (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .sampleValid(sampleValid),
      .sampleRaw(sampleRaw),
      .spanSel(fmtCtl_q[`APRC_FMT_SPAN_HI:0]),
      .scaledRes(fmtCtl_q[`APRC_FMT_SCALED]),
      .leftAlign(fmtCtl_q[`APRC_FMT_LEFT]),
      .sampleOut(axisData),
      .sampleOutValid(axisDataValid)
   );
endmodule

// ==== tb/aprc_regs_assertions.sv ====
// Checker for the power, interrupt and format register bank, bound to aprc_regs.
// Assumes single clock clk_sys and synchronous active-low rst_b.
`timescale 1ns/1ps
`include "aprc_consts.vh"
module aprc_regs_assertions (
   input wire clk_sys,
   input wire rst_b,
   input wire [5:0] regAddr,
   input wire regWrEn,
   input wire regRdEn,
   input wire [7:0] regWrData,
   input wire [7:0] regRdData_q,
   input wire [7:0] evtPulse,
   input wire axisDataRead,
   input wire irqLineA_q,
   input wire irqLineB_q,
   input wire measureOn_q,
   input wire sleepActive_q,
   input wire [3:0] dozeRateHz_q,
   input wire fifoWriteEn_q,
   input wire stimForce_q,
   input wire spiThreeWire_q,
   input wire [1:0] spanSel_q
);
   reg [7:0] enShadow_q;
   reg [7:0] routeShadow_q;
   reg invShadow_q;
   wire rdFlags = regRdEn && regAddr == `APRC_OFS_FLAGS;
   wire wrPower = regWrEn && regAddr == `APRC_OFS_POWER;
   wire wrFormat = regWrEn && regAddr == `APRC_OFS_FORMAT;
   // Shadows let line checks know the enables without peeking inside
   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         enShadow_q <= 8'h00;
         routeShadow_q <= 8'h00;
         invShadow_q <= 1'b0;
      end
      else
      begin
         if (regWrEn && regAddr == `APRC_OFS_IRQEN)
            enShadow_q <= regWrData;
         if (regWrEn && regAddr == `APRC_OFS_ROUTE)
            routeShadow_q <= regWrData;
         if (wrFormat)
            invShadow_q <= regWrData[5];
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   sequence s_tapToA;
      evtPulse[6] && !regWrEn && enShadow_q[6] && !routeShadow_q[6] && !invShadow_q ##1 !regWrEn && !rdFlags;
   endsequence
   sequence s_clearRead;
      rdFlags && evtPulse[6:2] == 5'h00 ##1 rdFlags;
   endsequence
   sequence s_keepRead;
      rdFlags && !axisDataRead ##1 rdFlags && !axisDataRead;
   endsequence
   property p_measure;
      wrPower |=> measureOn_q == $past(regWrData[3]);
   endproperty
   property p_format;
      wrFormat |=> {stimForce_q, spiThreeWire_q, spanSel_q} == {$past(regWrData[7:6]), $past(regWrData[1:0])};
   endproperty
   property p_doze;
      wrPower |-> ##2 dozeRateHz_q == (4'h8 >> $past(regWrData[1:0], 2));
   endproperty
   property p_lineA;
      s_tapToA |=> irqLineA_q;
   endproperty
   property p_quiet;
      enShadow_q == 8'h00 && $past(enShadow_q) == 8'h00 && $stable(invShadow_q)
         |-> irqLineA_q == invShadow_q && irqLineB_q == invShadow_q;
   endproperty
   property p_clear;
      s_clearRead |=> regRdData_q[6:2] == 5'h00;
   endproperty
   property p_keep;
      s_keepRead |=> &(regRdData_q | ~$past(regRdData_q) | 8'h7c);
   endproperty
   property p_noFifo;
      sleepActive_q [*2] |-> !fifoWriteEn_q;
   endproperty
   a_measure: assert property (p_measure) else $error("Measure output off");
   a_format: assert property (p_format) else $error("Format outputs off");
   a_doze: assert property (@(posedge clk_sys) p_doze) else $error("Doze rate off");
   a_lineA: assert property (p_lineA) else $error("Line A not raised");
   a_quiet: assert property (p_quiet) else $error("Line active without enable");
   a_clear: assert property (p_clear) else $error("Flags not cleared by read");
   a_keep: assert property (p_keep) else $error("Data flags lost on flag read");
   a_noFifo: assert property (p_noFifo) else $error("FIFO written while asleep");
endmodule

bind aprc_regs aprc_regs_assertions u_chk (
   .clk_sys, .rst_b, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData_q, .evtPulse,
   .axisDataRead, .irqLineA_q, .irqLineB_q, .measureOn_q, .sleepActive_q, .dozeRateHz_q,
   .fifoWriteEn_q, .stimForce_q, .spiThreeWire_q, .spanSel_q
);

// ==== tb/aprc_host_model.sv ====
// Host processor model: byte writes and reads on the register port.
// Assumes clk_sys from the bench; drives only at the falling edge.
`timescale 1ns/1ps
module aprc_host_model (
   input wire clk_sys,
   output reg [5:0] regAddr,
   output reg regWrEn,
   output reg regRdEn,
   output reg [7:0] regWrData,
   input wire [7:0] regRdData_q
);
   reg [7:0] rdVal;
   reg [7:0] rdFirst;
   initial
   begin
      regAddr = 6'h3f;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regWrData = 8'h00;
   end
   task wr(input [5:0] a, input [7:0] d);
   begin
      @(negedge clk_sys);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk_sys);
      regWrEn = 1'b0;
      // Released data flips so stale bytes are never mistaken for a write
      regWrData = ~d;
   end
   endtask
   // n back-to-back reads of one address; first and last results kept
   task rd(input [5:0] a, input integer n);
   begin
      @(negedge clk_sys);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk_sys);
      rdFirst = regRdData_q;
      repeat (n - 1) @(negedge clk_sys);
      regRdEn = 1'b0;
      rdVal = regRdData_q;
   end
   endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the register bank aprc_regs.
// Assumes the host model owns the register port; events and samples are driven here.
`timescale 1ns/1ps
`include "aprc_consts.vh"
module tb_top;
   reg clk_sys = 1'b0;
   reg rst_b = 1'b0;
   reg [7:0] evtPulse = 8'h00;
   reg axisDataRead = 1'b0;
   reg sampleValid = 1'b0;
   reg [12:0] sampleRaw = 13'h0000;
   reg actFuncOn = 1'b1;
   reg inactFuncOn = 1'b1;
   wire lowPower_q;
   wire stimForce_q;
   wire spiThreeWire_q;
   wire [1:0] spanSel_q;
   wire actDetectEn_q;
   wire inactDetectEn_q;
   wire [5:0] regAddr;
   wire regWrEn;
   wire regRdEn;
   wire [7:0] regWrData;
   wire [7:0] regRdData_q;
   wire irqLineA_q;
   wire irqLineB_q;
   wire [3:0] rateCode_q;
   wire measureOn_q;
   wire sleepActive_q;
   wire [3:0] dozeRateHz_q;
   wire fifoWriteEn_q;
   wire [15:0] axisData;
   wire axisDataValid;
   integer fail_count = 0;
   integer check_count = 0;
   integer i;
   reg [21:0] rows [0:6];
   always #2.5 clk_sys = ~clk_sys;
   aprc_host_model host (.clk_sys, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData_q);
   // Function-on levels are driven so chained and concurrent detection both get exercised
   aprc_regs dut (
      .clk_sys, .rst_b, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData_q, .evtPulse,
      .axisDataRead, .sampleValid, .sampleRaw, .actFuncOn, .inactFuncOn, .irqLineA_q,
      .irqLineB_q, .lowPower_q, .rateCode_q, .measureOn_q, .sleepActive_q, .dozeRateHz_q,
      .fifoWriteEn_q, .actDetectEn_q, .inactDetectEn_q, .stimForce_q, .spiThreeWire_q,
      .spanSel_q, .axisData, .axisDataValid
   );
   task chk(input [15:0] seen, input [15:0] exp);
   begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task end_of_test;
   begin
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   task pulse(input [7:0] e);
   begin
      @(negedge clk_sys);
      evtPulse = e;
      @(negedge clk_sys);
      evtPulse = 8'h00;
   end
   endtask
   task doReset;
   begin
      @(negedge clk_sys);
      rst_b = 1'b0;
      repeat (5) @(negedge clk_sys);
      rst_b = 1'b1;
   end
   endtask
   task samp(input [12:0] raw, input [7:0] fmt, input [15:0] exp);
   begin
      host.wr(`APRC_OFS_FORMAT, fmt);
      @(negedge clk_sys);
      sampleValid = 1'b1;
      sampleRaw = raw;
      @(negedge clk_sys);
      sampleValid = 1'b0;
      chk(axisDataValid, 16'h0001);
      chk(axisData, exp);
   end
   endtask
   initial
   begin
      rows[0] = {`APRC_OFS_RATE, 8'hff, 8'h1f};
      rows[1] = {`APRC_OFS_POWER, 8'hf3, 8'h33};
      rows[2] = {`APRC_OFS_IRQEN, 8'ha5, 8'ha5};
      rows[3] = {`APRC_OFS_ROUTE, 8'h5a, 8'h5a};
      rows[4] = {`APRC_OFS_FORMAT, 8'hff, 8'hef};
      rows[5] = {`APRC_OFS_FLAGS, 8'hff, 8'h00};
      rows[6] = {6'h3f, 8'ha5, 8'h00};
      doReset;
      for (i = 0; i < 7; i = i + 1)
      begin
         host.wr(rows[i][21:16], rows[i][15:8]);
         host.rd(rows[i][21:16], 1);
         chk(host.rdVal, rows[i][7:0]);
      end
      chk({lowPower_q, stimForce_q, spiThreeWire_q, spanSel_q}, 16'h001f);
      chk({actDetectEn_q, inactDetectEn_q}, 16'h0000);
      // Mid-run reset must bring every register back
      doReset;
      chk({rateCode_q, dozeRateHz_q, 3'b000, measureOn_q}, 16'h0a80);
      for (i = 6'h2c; i < 6'h32; i = i + 1)
      begin
         host.rd(i[5:0], 1);
         chk(host.rdVal, (i == 6'h2c) ? 8'h0a : 8'h00);
      end
      host.wr(`APRC_OFS_IRQEN, 8'h40);
      pulse(8'h40);
      @(negedge clk_sys);
      chk({irqLineA_q, irqLineB_q}, 16'h0002);
      host.wr(`APRC_OFS_ROUTE, 8'h40);
      @(negedge clk_sys);
      chk({irqLineA_q, irqLineB_q}, 16'h0001);
      host.wr(`APRC_OFS_FORMAT, 8'h20);
      @(negedge clk_sys);
      chk({irqLineA_q, irqLineB_q}, 16'h0002);
      host.rd(`APRC_OFS_FLAGS, 2);
      chk({host.rdFirst, host.rdVal}, 16'h4000);
      @(negedge clk_sys);
      chk({irqLineA_q, irqLineB_q}, 16'h0003);
      host.wr(`APRC_OFS_FORMAT, 8'h00);
      host.wr(`APRC_OFS_IRQEN, 8'h00);
      pulse(8'h83);
      host.rd(`APRC_OFS_FLAGS, 2);
      chk(host.rdVal, 8'h83);
      chk({irqLineA_q, irqLineB_q}, 16'h0000);
      @(negedge clk_sys);
      axisDataRead = 1'b1;
      @(negedge clk_sys);
      axisDataRead = 1'b0;
      host.rd(`APRC_OFS_FLAGS, 1);
      chk(host.rdVal, 8'h00);
      host.wr(`APRC_OFS_POWER, 8'h0c);
      pulse(8'h80);
      host.rd(`APRC_OFS_FLAGS, 1);
      chk({host.rdVal, 7'h00, fifoWriteEn_q}, 16'h0000);
      host.wr(`APRC_OFS_POWER, 8'h00);
      host.wr(`APRC_OFS_POWER, 8'h08);
      @(negedge clk_sys);
      chk({sleepActive_q, fifoWriteEn_q}, 16'h0001);
      for (i = 0; i < 4; i = i + 1)
      begin
         host.wr(`APRC_OFS_POWER, i[7:0]);
         @(negedge clk_sys);
         chk(dozeRateHz_q, 16'h0008 >> i);
      end
      host.wr(`APRC_OFS_POWER, 8'h38);
      @(negedge clk_sys);
      chk({actDetectEn_q, inactDetectEn_q}, 16'h0001);
      pulse(8'h08);
      repeat (2) @(negedge clk_sys);
      chk({sleepActive_q, actDetectEn_q, inactDetectEn_q}, 16'h0006);
      pulse(8'h10);
      repeat (2) @(negedge clk_sys);
      chk({sleepActive_q, actDetectEn_q, inactDetectEn_q}, 16'h0001);
      inactFuncOn = 1'b0;
      @(negedge clk_sys);
      chk({actDetectEn_q, inactDetectEn_q}, 16'h0002);
      inactFuncOn = 1'b1;
      host.wr(`APRC_OFS_POWER, 8'h00);
      host.wr(`APRC_OFS_POWER, 8'h08);
      @(negedge clk_sys);
      chk({actDetectEn_q, inactDetectEn_q}, 16'h0003);
      host.wr(`APRC_OFS_POWER, 8'h00);
      samp(13'h0fff, 8'h00, 16'h01ff);
      samp(13'h1000, 8'h0b, 16'hf000);
      samp(13'h0001, 8'h04, 16'h0040);
      samp(13'h1ff0, 8'h01, 16'hfff8);
      end_of_test;
   end
   // A hang far beyond the roughly 140 cycles of the sequence counts as a failure
   initial
   begin
      #20000;
      fail_count = fail_count + 1;
      end_of_test;
   end
endmodule
